// ---- fpp_consts.svh ----
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH

// register byte offsets
`define FPP_A_CTRL     8'h00
`define FPP_A_KEY      8'h04
`define FPP_A_PAGE     8'h08
`define FPP_A_OFFS     8'h0C
`define FPP_A_STLO     8'h10
`define FPP_A_STHI     8'h14
`define FPP_A_ISTAT    8'h18
`define FPP_A_ICLR     8'h1C
`define FPP_A_IEN      8'h20
`define FPP_A_TADDR    8'h24

// flash_control_reg field positions
`define FPP_B_GO       15
`define FPP_B_PERMIT   14
`define FPP_B_FAULT    13
`define FPP_B_ERASE    6
`define FPP_OP_MSB     3
`define FPP_OP_LSB     0

// operation_select codes
`define FPP_OP_CFG     4'h0
`define FPP_OP_ROW     4'h1
`define FPP_OP_PAGE    4'h2
`define FPP_OP_WORD    4'h3
`define FPP_OP_SEC     4'hC
`define FPP_OP_GEN     4'hD
`define FPP_OP_BULK    4'hF

// unlock keys and key tracker states
`define FPP_KEY_1      8'h55
`define FPP_KEY_2      8'hAA
`define FPP_KS_NONE    2'h0
`define FPP_KS_ONE     2'h1
`define FPP_KS_TWO     2'h2

// interrupt status bit positions
`define FPP_S_DONE     0
`define FPP_S_FAULT    1

// table pointer post-increment, one instruction
`define FPP_INC        16'h0002

// timing
`define FPP_CLK_NS     10
`define FPP_ROW_NS     1435000
`define FPP_ERASE_NS   1435000
`define FPP_WORD_NS    1435000
`define FPP_ROW_WORDS  64

`endif

// ---- fpp_pkg.sv ----
package fpp_pkg;

    typedef enum logic [2:0] {
        FPP_ST_IDLE   = 3'b000,
        FPP_ST_STREAM = 3'b001,
        FPP_ST_ISSUE  = 3'b010,
        FPP_ST_WAIT   = 3'b011
    } fpp_state_t;

    typedef enum logic [3:0] {
        FPP_CMD_NONE  = 4'b0000,
        FPP_CMD_ROW   = 4'b0001,
        FPP_CMD_WORD  = 4'b0010,
        FPP_CMD_PAGE  = 4'b0011,
        FPP_CMD_BULK  = 4'b0100,
        FPP_CMD_GEN   = 4'b0101,
        FPP_CMD_SEC   = 4'b0110,
        FPP_CMD_CFGE  = 4'b0111,
        FPP_CMD_CFGP  = 4'b1000
    } fpp_cmd_t;

endpackage

// ---- fpp_latch_mem.sv ----
`timescale 1ns/10ps

module fpp_latch_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // write port
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input  wire logic [WIDTH-1:0]         wmask_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic      [WIDTH-1:0]         rdata_o
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("fpp_latch_mem: bad geometry");
    end

    // array itself has no reset; contents are undefined until loaded
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= (mem_q[waddr_i] & ~wmask_i) |
                              (wdata_i & wmask_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end

endmodule

// ---- fpp_top.sv ----
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "fpp_consts.svh"

// Function
// R1: software programs one row after page erase
// R2: software saves and merges page before erase
// R3: page erase is op 0010 with erase, permit
// R4: store low latches erase page start address
// R5: keys 0x55 then 0xAA must precede go
// R6: go on erase stalls core, self-clears
// R7: buffer loads low word then high byte
// R8: table stores touch only holding latches
// R9: row program is op 0001, erase clear
// R10: row program stalls core, go self-clears
// R11: software repeats rows across whole page
// R12: software adds two nops, waits time
// R13: software blocks interrupts around unlock
// R14: fault flag on bad sequence or termination
// R15: permit bit clear inhibits all operations
// R16: decode remaining erase and program codes
// R17: control bits reset only on power-on
// R18: go without fresh key pair faults
// R19: row program writes aligned 64-word row
module fpp_top
    import fpp_pkg::*;
#(
    parameter int unsigned ROW_WORDS = `FPP_ROW_WORDS,
    parameter int unsigned ROW_CYC   =
        (`FPP_ROW_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
    parameter int unsigned ERASE_CYC =
        (`FPP_ERASE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
    parameter int unsigned WORD_CYC  =
        (`FPP_WORD_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS
) (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    // core and interrupt
    output logic             core_stall_o,
    output logic             irq_o,
    // flash array
    output logic             flash_strobe_o,
    output logic      [3:0]  flash_cmd_o,
    output logic      [23:0] flash_addr_o,
    output logic      [23:0] flash_wdata_o
);

    localparam int IDX_W = $clog2(ROW_WORDS);
    localparam int BASE_W = 23 - IDX_W;

    if (ROW_WORDS < 2 || ROW_WORDS > 128 ||
        (1 << IDX_W) != ROW_WORDS ||
        ROW_CYC < 1 || ERASE_CYC < 1 || WORD_CYC < 1) begin : g_chk
        $error("fpp_top: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] fpp_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic fpp_cmd_t fpp_decode(input logic       erase,
                                            input logic [3:0] op);
        fpp_cmd_t c;
        c = FPP_CMD_NONE;
        if (erase) begin
            case (op)
                `FPP_OP_PAGE: c = FPP_CMD_PAGE;
                `FPP_OP_BULK: c = FPP_CMD_BULK;
                `FPP_OP_GEN:  c = FPP_CMD_GEN;
                `FPP_OP_SEC:  c = FPP_CMD_SEC;
                `FPP_OP_CFG:  c = FPP_CMD_CFGE;
                default:      c = FPP_CMD_NONE;
            endcase
        end else begin
            case (op)
                `FPP_OP_ROW:  c = FPP_CMD_ROW;
                `FPP_OP_WORD: c = FPP_CMD_WORD;
                `FPP_OP_CFG:  c = FPP_CMD_CFGP;
                default:      c = FPP_CMD_NONE;
            endcase
        end
        return c;
    endfunction

    function automatic logic [31:0] fpp_cycles(input fpp_cmd_t c);
        logic [31:0] n;
        case (c)
            FPP_CMD_ROW:  n = 32'(ROW_CYC);
            FPP_CMD_WORD: n = 32'(WORD_CYC);
            FPP_CMD_CFGP: n = 32'(WORD_CYC);
            default:      n = 32'(ERASE_CYC);
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    logic             rst_any;
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [31:0]      rd_w;
    logic [7:0]       wadr_w;
    logic             wr_fire;
    logic             go_q;
    logic             permit_q;
    logic             fault_q;
    logic             erase_q;
    logic [3:0]       op_q;
    logic [15:0]      ctrl_rd;
    logic [31:0]      ctrl_new;
    fpp_cmd_t         new_cmd;
    logic             go_try;
    logic             start_w;
    logic             bad_w;
    logic             fin_w;
    logic [1:0]       key_q;
    logic [7:0]       page_q;
    logic [15:0]      offs_q;
    logic [23:0]      taddr_q;
    logic             mem_we;
    logic [23:0]      mem_mask;
    logic [23:0]      mem_rdata;
    fpp_state_t       state_q;
    fpp_cmd_t         cmd_q;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] vidx_q;
    logic [IDX_W:0]   left_q;
    logic             vld_q;
    logic [BASE_W-1:0] base_q;
    logic [31:0]      timer_q;
    logic [1:0]       st_q;
    logic [1:0]       en_q;
    logic [1:0]       st_set;
    logic [7:0]       strb_cnt_q;

    assign rst_any  = rst_i | por_i;
    assign wadr_w   = {wb_adr_i[7:2], 2'b00};
    assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign ctrl_rd  = {go_q, permit_q, fault_q, 6'h00, erase_q, 2'b00, op_q};
    assign ctrl_new = fpp_merge({16'h0000, ctrl_rd}, wb_dat_i, wb_sel_i);
    assign new_cmd  = fpp_decode(ctrl_new[`FPP_B_ERASE],
                                 ctrl_new[`FPP_OP_MSB:`FPP_OP_LSB]); // [R16]
    assign go_try   = wr_fire & (wadr_w == `FPP_A_CTRL) & ~go_q &
                      ctrl_new[`FPP_B_GO];
    assign start_w  = go_try & (key_q == `FPP_KS_TWO) &                 // [R5]
                      ctrl_new[`FPP_B_PERMIT] &                         // [R15]
                      (new_cmd != FPP_CMD_NONE);
    assign bad_w    = go_try & ~start_w;                                // [R18]
    assign fin_w    = (state_q == FPP_ST_WAIT) && (timer_q == 32'h0000_0001);

    ////////////////////////////////////////////////////////////////////////
    // wishbone: ack one cycle after request, write lands at the ack edge

    always_comb begin
        rd_w = 32'h0000_0000;
        case (wadr_w)
            `FPP_A_CTRL:  rd_w = {16'h0000, ctrl_rd};
            `FPP_A_PAGE:  rd_w = {24'h00_0000, page_q};
            `FPP_A_OFFS:  rd_w = {16'h0000, offs_q};
            `FPP_A_ISTAT: rd_w = {30'h0000_0000, st_q};
            `FPP_A_IEN:   rd_w = {30'h0000_0000, en_q};
            `FPP_A_TADDR: rd_w = {8'h00, taddr_q};
            default:      rd_w = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                dat_q <= wb_we_i ? 32'h0000_0000 : rd_w;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////
    // flash_control_reg: plain system reset must not wipe it

    always_ff @(posedge clk_i) begin
        if (por_i) begin                                                // [R17]
            go_q     <= 1'b0;
            permit_q <= 1'b0;
            fault_q  <= 1'b0;
            erase_q  <= 1'b0;
            op_q     <= `FPP_OP_CFG;
        end else if (rst_i) begin
            if (go_q) begin
                go_q    <= 1'b0;
                fault_q <= 1'b1;                                        // [R14]
            end
        end else begin
            // fields frozen while a cycle runs
            if (wr_fire && wadr_w == `FPP_A_CTRL && !go_q) begin
                permit_q <= ctrl_new[`FPP_B_PERMIT];
                erase_q  <= ctrl_new[`FPP_B_ERASE];                     // [R3]
                op_q     <= ctrl_new[`FPP_OP_MSB:`FPP_OP_LSB];          // [R9]
                fault_q  <= ctrl_new[`FPP_B_FAULT];
            end
            if (start_w) begin
                go_q <= 1'b1;                                           // [R6]
            end
            if (fin_w) begin
                go_q <= 1'b0;                                           // [R10]
            end
            if (bad_w) begin
                fault_q <= 1'b1;                                        // [R14]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // key tracker: any other write in between breaks the pair

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            key_q <= `FPP_KS_NONE;
        end else if (wr_fire) begin
            if (wadr_w == `FPP_A_KEY && wb_dat_i[7:0] == `FPP_KEY_1) begin
                key_q <= `FPP_KS_ONE;                                   // [R5]
            end else if (wadr_w == `FPP_A_KEY && key_q == `FPP_KS_ONE &&
                         wb_dat_i[7:0] == `FPP_KEY_2) begin
                key_q <= `FPP_KS_TWO;                                   // [R5]
            end else begin
                key_q <= `FPP_KS_NONE;                                  // [R18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table pointer, erase address latch, holding latches

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            page_q  <= 8'h00;
            offs_q  <= 16'h0000;
            taddr_q <= 24'h00_0000;
        end else if (wr_fire && !go_q) begin
            if (wadr_w == `FPP_A_PAGE) begin
                page_q <= 8'(fpp_merge({24'h00_0000, page_q}, wb_dat_i,
                                       wb_sel_i));
            end
            if (wadr_w == `FPP_A_OFFS) begin
                offs_q <= 16'(fpp_merge({16'h0000, offs_q}, wb_dat_i,
                                        wb_sel_i));
            end
            if (wadr_w == `FPP_A_STLO) begin
                taddr_q <= {page_q, offs_q};                            // [R4]
            end
            if (wadr_w == `FPP_A_STHI) begin
                offs_q <= offs_q + `FPP_INC;                            // [R7]
            end
        end
    end

    // stores only reach the latches, never the array
    assign mem_we   = wr_fire & ~go_q &                                 // [R8]
                      ((wadr_w == `FPP_A_STLO) | (wadr_w == `FPP_A_STHI));
    assign mem_mask = (wadr_w == `FPP_A_STLO) ? 24'h00_FFFF : 24'hFF_0000;

    fpp_latch_mem #(
        .WIDTH (24),
        .DEPTH (ROW_WORDS)
    ) u_latch (
        .clk_i   (clk_i),
        .rst_i   (rst_any),
        .we_i    (mem_we),
        .waddr_i (offs_q[IDX_W:1]),
        .wmask_i (mem_mask),
        .wdata_i ({wb_dat_i[7:0], wb_dat_i[15:0]}),
        .raddr_i (idx_q),
        .rdata_o (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            state_q <= FPP_ST_IDLE;
            cmd_q   <= FPP_CMD_NONE;
            idx_q   <= '0;
            vidx_q  <= '0;
            left_q  <= '0;
            vld_q   <= 1'b0;
            base_q  <= '0;
            timer_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                FPP_ST_IDLE: begin
                    vld_q <= 1'b0;
                    if (start_w) begin
                        cmd_q  <= new_cmd;
                        base_q <= taddr_q[23:IDX_W+1];                  // [R19]
                        if (new_cmd == FPP_CMD_ROW) begin
                            idx_q   <= '0;
                            left_q  <= (IDX_W+1)'(ROW_WORDS);
                            state_q <= FPP_ST_STREAM;
                        end else if (new_cmd == FPP_CMD_WORD) begin
                            idx_q   <= taddr_q[IDX_W:1];
                            left_q  <= (IDX_W+1)'(1);
                            state_q <= FPP_ST_STREAM;
                        end else begin
                            state_q <= FPP_ST_ISSUE;
                        end
                    end
                end
                FPP_ST_STREAM: begin
                    // latch read is registered, so words trail by a cycle
                    if (left_q != '0) begin
                        idx_q  <= idx_q + IDX_W'(1);
                        vidx_q <= idx_q;
                        left_q <= left_q - (IDX_W+1)'(1);
                        vld_q  <= 1'b1;
                    end else begin
                        vld_q <= 1'b0;
                    end
                    if (left_q == '0 && !vld_q) begin
                        timer_q <= fpp_cycles(cmd_q);
                        state_q <= FPP_ST_WAIT;
                    end
                end
                FPP_ST_ISSUE: begin
                    timer_q <= fpp_cycles(cmd_q);
                    state_q <= FPP_ST_WAIT;                             // [R6]
                end
                FPP_ST_WAIT: begin
                    timer_q <= timer_q - 32'h0000_0001;
                    if (fin_w) begin
                        state_q <= FPP_ST_IDLE;
                    end
                end
                default: state_q <= FPP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            flash_strobe_o <= 1'b0;
            flash_cmd_o    <= FPP_CMD_NONE;
            flash_addr_o   <= 24'h00_0000;
            flash_wdata_o  <= 24'h00_0000;
            core_stall_o   <= 1'b0;
        end else begin
            flash_strobe_o <= (state_q == FPP_ST_STREAM && vld_q) ||
                              (state_q == FPP_ST_ISSUE);
            flash_cmd_o    <= cmd_q;
            if (state_q == FPP_ST_STREAM) begin
                flash_addr_o  <= {base_q, vidx_q, 1'b0};                // [R19]
                flash_wdata_o <= mem_rdata;
            end else if (state_q == FPP_ST_ISSUE) begin
                flash_addr_o  <= taddr_q;                               // [R4]
                flash_wdata_o <= 24'h00_0000;
            end
            core_stall_o <= (go_q | start_w) & ~fin_w;                  // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over clear

    assign st_set = {bad_w, fin_w};

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            st_q  <= 2'b00;
            en_q  <= 2'b00;
            irq_o <= 1'b0;
        end else begin
            if (wr_fire && wadr_w == `FPP_A_ICLR) begin
                st_q <= (st_q & ~wb_dat_i[1:0]) | st_set;
            end else begin
                st_q <= st_q | st_set;
            end
            if (wr_fire && wadr_w == `FPP_A_IEN) begin
                en_q <= 2'(fpp_merge({30'h0000_0000, en_q}, wb_dat_i,
                                     wb_sel_i));
            end
            irq_o <= |(st_q & en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i) begin
        if (rst_any || start_w) begin
            strb_cnt_q <= 8'h00;
        end else if (flash_strobe_o) begin
            strb_cnt_q <= strb_cnt_q + 8'h01;
        end
    end

    sequence s_issue_step;
        state_q == FPP_ST_ISSUE ##1 (state_q == FPP_ST_WAIT && flash_strobe_o);
    endsequence

    sequence s_go_done;
        !go_q && !core_stall_o && st_q[`FPP_S_DONE];
    endsequence

    unlock_needed_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R5]
        $rose(go_q) |-> $past(key_q) == `FPP_KS_TWO && permit_q)
        else $error("go rose without unlock or permit");

    bad_go_fault_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R18]
        go_try && key_q != `FPP_KS_TWO |=> fault_q && !go_q)
        else $error("unkeyed go not refused");

    permit_gate_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R15]
        flash_strobe_o |-> permit_q)
        else $error("array strobed without permit");

    stall_go_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R6]
        core_stall_o == go_q)
        else $error("stall differs from go");

    erase_issue_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R6]
        start_w && ctrl_new[`FPP_B_ERASE] |=> s_issue_step)
        else $error("erase not issued");

    go_clears_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R10]
        fin_w |=> s_go_done)
        else $error("go not cleared at end");

    row_count_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R19]
        fin_w |-> strb_cnt_q == ((cmd_q == FPP_CMD_ROW) ?
                                 8'(ROW_WORDS) : 8'h01))
        else $error("wrong number of array writes");

    page_cmd_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R3]
        flash_strobe_o && flash_cmd_o == FPP_CMD_PAGE |->
            erase_q && op_q == `FPP_OP_PAGE)
        else $error("page erase with wrong selection");

    row_cmd_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R9]
        flash_strobe_o && flash_cmd_o == FPP_CMD_ROW |->
            !erase_q && op_q == `FPP_OP_ROW)
        else $error("row program with wrong selection");

    latch_only_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R8]
        state_q == FPP_ST_IDLE && $past(state_q) == FPP_ST_IDLE
            |-> !flash_strobe_o)
        else $error("array touched while idle");

    post_inc_a: assert property (@(posedge clk_i) disable iff (rst_any) // [R7]
        wr_fire && wadr_w == `FPP_A_STHI && !go_q |=>
            offs_q == $past(offs_q) + `FPP_INC)
        else $error("pointer not post-incremented");

    por_only_a: assert property (@(posedge clk_i) disable iff (por_i) // [R17]
        rst_i |=> $stable({permit_q, erase_q, op_q}))
        else $error("control changed by system reset");

endmodule

// ---- fpp_flash_model.sv ----
`timescale 1ns/10ps

module fpp_flash_model (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // array command side
    input  wire logic        strobe_i,
    input  wire logic [3:0]  cmd_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [23:0] wdata_i,
    // record seen by the bench
    output logic      [7:0]  n_o,
    output logic      [3:0]  cmd_o,
    output logic      [23:0] addr_o,
    output logic      [23:0] sum_o
);
    // only strobed commands reach the array, stores alone never do
    // folded sum instead of a full array: cheap, still order-blind
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            n_o    <= 8'h00;
            cmd_o  <= 4'h0;
            addr_o <= 24'h00_0000;
            sum_o  <= 24'h00_0000;
        end else if (strobe_i) begin
            n_o    <= n_o + 8'h01;
            cmd_o  <= cmd_i;
            addr_o <= addr_i;
            sum_o  <= sum_o ^ wdata_i ^ addr_i;
        end
    end
endmodule

// ---- fpp_top_bench.sv ----
`timescale 1ns/10ps
`include "fpp_consts.svh"

module fpp_top_bench;
    import fpp_pkg::*;
    logic        clk_i = 0, rst_i = 1, por_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00, pg, mn, n0, hi;
    logic [31:0] dat = 32'h0000_0000, r, dato;
    logic [15:0] of, lo;
    logic [23:0] es, s0, fa, fw, ma, ms;
    logic [3:0]  fc, mc, sel = 4'hF, sm = 4'hF;
    logic        ack, stall, irq, fs;
    logic [4:0]  op [6] = '{5'h1F, 5'h1D, 5'h1C, 5'h10, 5'h03, 5'h00};
    fpp_cmd_t    ec [6] = '{FPP_CMD_BULK, FPP_CMD_GEN, FPP_CMD_SEC,
                            FPP_CMD_CFGE, FPP_CMD_WORD, FPP_CMD_CFGP};
    int          n_mismatch = 0, n_compared = 0;

    fpp_top #(.ROW_CYC(20), .ERASE_CYC(20), .WORD_CYC(20)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dato),
        .core_stall_o(stall), .irq_o(irq), .flash_strobe_o(fs),
        .flash_cmd_o(fc), .flash_addr_o(fa), .flash_wdata_o(fw));
    fpp_flash_model FM (
        .clk_i(clk_i), .rst_i(rst_i), .strobe_i(fs), .cmd_i(fc),
        .addr_i(fa), .wdata_i(fw), .n_o(mn), .cmd_o(mc), .addr_o(ma),
        .sum_o(ms));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= sm;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic go(input logic [31:0] c);
        wb(1, `FPP_A_KEY, 32'h0000_0055);
        wb(1, `FPP_A_KEY, 32'h0000_00AA);
        wb(1, `FPP_A_CTRL, c | 32'h0000_8000);
        @(posedge clk_i);
        cmp({31'h0, stall}, {31'h0, c[14]});
    endtask
    task automatic wt();
        int n;
        n = 0;
        while (stall !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h7ce8bf72);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        wb(0, `FPP_A_CTRL, 0);
        cmp(r, 32'h0000_0000);
        wb(1, `FPP_A_IEN, 32'h0000_0003);
        pg = 8'($urandom);
        of = 16'($urandom) & 16'hFF80;
        // erase the page before touching a row of it
        wb(1, `FPP_A_PAGE, {24'h0, pg});
        wb(1, `FPP_A_OFFS, {16'h0, of});
        wb(1, `FPP_A_STLO, $urandom);
        wb(0, `FPP_A_TADDR, 0);
        cmp(r, {8'h0, pg, of});
        n0 = mn;
        go(32'h0000_4042);
        wt();
        cmp(mn, n0 + 8'h01);
        cmp(mc, FPP_CMD_PAGE);
        cmp(ma, {pg, of});
        wb(0, `FPP_A_CTRL, 0);
        cmp(r, 32'h0000_4042);
        cmp({31'h0, irq}, 32'h0000_0001);
        wb(1, `FPP_A_ICLR, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        cmp({31'h0, irq}, 32'h0000_0000);
        // low word then high byte for each of 64 words
        wb(1, `FPP_A_OFFS, {16'h0, of});
        es = 24'h00_0000;
        n0 = mn;
        s0 = ms;
        for (int i = 0; i < 64; i++) begin
            lo = 16'($urandom);
            hi = 8'($urandom);
            wb(1, `FPP_A_STLO, {16'h0, lo});
            wb(1, `FPP_A_STHI, {24'h0, hi});
            es = es ^ {hi, lo} ^ {pg, of[15:7], 6'(i), 1'b0};
        end
        cmp(mn, n0);
        go(32'h0000_4001);
        wt();
        cmp(mn, n0 + 8'h40);
        cmp(ms, s0 ^ es);
        cmp(mc, FPP_CMD_ROW);
        // system reset mid-cycle terminates the row
        go(32'h0000_4001);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `FPP_A_CTRL, 0);
        cmp(r, 32'h0000_6001);
        for (int k = 0; k < 6; k++) begin
            n0 = mn;
            go({24'h40, 1'b0, op[k][4], 2'b0, op[k][3:0]});
            wt();
            cmp(mn, n0 + 8'h01);
            cmp(mc, ec[k]);
        end
        wb(1, `FPP_A_ICLR, 32'h0000_0003);
        wb(1, `FPP_A_IEN, 32'h0000_0001);
        n0 = mn;
        wb(1, `FPP_A_CTRL, 32'h0000_C001);
        wb(0, `FPP_A_CTRL, 0);
        cmp(r, 32'h0000_6001);
        wb(1, `FPP_A_CTRL, 32'h0000_4001);
        go(32'h0000_0001);
        repeat (2) @(posedge clk_i);
        cmp({31'h0, irq}, 32'h0000_0000);
        wb(0, `FPP_A_CTRL, 0);
        cmp(r, 32'h0000_2001);
        cmp(mn, n0);
        wb(0, `FPP_A_ISTAT, 0);
        cmp(r, 32'h0000_0002);
        wb(1, `FPP_A_IEN, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        cmp({31'h0, irq}, 32'h0000_0001);
        sm = 4'h2;
        wb(1, `FPP_A_OFFS, 32'h0000_ABCD);
        sm = 4'hF;
        wb(0, `FPP_A_OFFS, 0);
        cmp(r, 32'h0000_AB00);
        wb(0, 8'hF0, 0);
        cmp(r, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
